// ===== sfb_front_end.sv
// Functional notes
// R1 - Single line: capture input on rising clock
// R2 - Output changes only after falling clock edges
// R3 - Clock modes 0 and 3 work unconfigured
// R4 - Host keeps clock level steady at selects
// R5 - Two-line: input and output pins both bidirectional
// R6 - Four-line: all four pins become data
// R7 - Four-line only while four-line enable set
// R8 - Deselected: every data line high impedance
// R9 - Internal operations continue after deselect
// R10 - Ignore instructions until first select fall
// R11 - Multi-line: capture rising, drive after falling
// R12 - Write-protect low with lock blocks range writes
// R13 - Pause only in one/two-line, state preserved
// R14 - Pause on pause fall if clock low
// R15 - Leave pause on falling clock, pin high
// R16 - Paused: output off, input and clock ignored
// R17 - Host keeps select low during pause
// R18 - Four-line enable disables pause function
// R19 - Every byte moves most significant bit first
// R20 - Select rise abandons partial instruction
// R21 - Pause keeps bit counters and shift registers
`timescale 1ns/1ps
module sfb_front_end (
  input wire logic clk,
  input wire logic rst_b,
  input wire sfb_pkg::sfb_pin_in_t pins_in,
  output sfb_pkg::sfb_pin_out_t pins_out,
  input wire logic four_line_enable,
  input wire sfb_pkg::sfb_width_t width_sel,
  input wire logic tx_en,
  input wire logic [7:0] tx_data,
  output logic tx_taken,
  output sfb_pkg::sfb_byte_t rx,
  output logic selected,
  output logic paused,
  output logic frame_start,
  output logic frame_end,
  output logic frame_abort,
  output logic quad_refused,
  input wire logic set_stb,
  input wire sfb_pkg::sfb_lock_reg_t set_data,
  output sfb_pkg::sfb_lock_reg_t lock_reg,
  output logic set_reject
);

  typedef struct packed {
    sfb_pkg::sfb_state_t state;
    logic sclk_q;
    logic [7:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [7:0] tx_sh;
    logic [3:0] tx_cnt;
    sfb_pkg::sfb_pin_out_t pout;
    sfb_pkg::sfb_byte_t rx;
    logic tx_taken;
    logic frame_start;
    logic frame_end;
    logic frame_abort;
    logic quad_refused;
    logic wp_low;
    logic selected;
    logic paused;
  } sfb_fe_state_t;

  localparam sfb_fe_state_t FE_RESET = '{
    state: sfb_pkg::SFB_ST_WAIT,
    pout: '{io: sfb_pkg::SFB_IO_IDLE, oe_b: sfb_pkg::SFB_OE_NONE},
    default: '0
  };

  sfb_fe_state_t st;
  sfb_fe_state_t next_st;

  logic [5:0] sync_raw;
  sfb_pkg::sfb_pin_in_t pin;

  localparam logic [7:0] SFB_BYTE_ZERO_W = sfb_pkg::SFB_BYTE_ZERO;

  // Pins cross from the host's clock into ours
  sfb_pin_sync #(
    .WIDTH(6)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(pins_in),
    .stable(sync_raw)
  );

  assign pin = sync_raw;

  // Bits moved per edge for a width
  function automatic logic [3:0] sfb_step(input sfb_pkg::sfb_width_t w);
    logic [3:0] s;
    s = sfb_pkg::SFB_STEP_W1;
    case (w)
      sfb_pkg::SFB_W2: begin
        s = sfb_pkg::SFB_STEP_W2;
      end
      sfb_pkg::SFB_W4: begin
        s = sfb_pkg::SFB_STEP_W4;
      end
      default: begin
        s = sfb_pkg::SFB_STEP_W1;
      end
    endcase
    return s;
  endfunction : sfb_step

  // Lanes driven for a width
  function automatic logic [3:0] sfb_drive(input sfb_pkg::sfb_width_t w);
    logic [3:0] m;
    m = sfb_pkg::SFB_DRIVE_W1;
    case (w)
      sfb_pkg::SFB_W2: begin
        m = sfb_pkg::SFB_DRIVE_W2; // [R5]
      end
      sfb_pkg::SFB_W4: begin
        m = sfb_pkg::SFB_DRIVE_W4; // [R6]
      end
      default: begin
        m = sfb_pkg::SFB_DRIVE_W1;
      end
    endcase
    return m;
  endfunction : sfb_drive

  // New bits enter at the bottom, so the first bit ends up on top
  function automatic logic [7:0] sfb_rx_shift(
    input logic [7:0] sh,
    input logic [3:0] io,
    input sfb_pkg::sfb_width_t w
  );
    logic [7:0] r;
    r = {sh[6:0], io[sfb_pkg::SFB_LANE_SI]}; // [R1] [R19]
    case (w)
      sfb_pkg::SFB_W2: begin
        r = {sh[5:0], io[sfb_pkg::SFB_LANE_SO],
             io[sfb_pkg::SFB_LANE_SI]}; // [R5]
      end
      sfb_pkg::SFB_W4: begin
        r = {sh[3:0], io}; // [R6]
      end
      default: begin
        r = {sh[6:0], io[sfb_pkg::SFB_LANE_SI]};
      end
    endcase
    return r;
  endfunction : sfb_rx_shift

  // Top bits of the byte go out first, highest lane carries the highest bit
  function automatic logic [3:0] sfb_tx_lanes(
    input logic [7:0] b,
    input sfb_pkg::sfb_width_t w
  );
    logic [3:0] o;
    o = sfb_pkg::SFB_IO_IDLE;
    case (w)
      sfb_pkg::SFB_W2: begin
        o[sfb_pkg::SFB_LANE_SO] = b[7]; // [R19]
        o[sfb_pkg::SFB_LANE_SI] = b[6];
      end
      sfb_pkg::SFB_W4: begin
        o = b[7:4]; // [R19]
      end
      default: begin
        o[sfb_pkg::SFB_LANE_SO] = b[7]; // [R19]
      end
    endcase
    return o;
  endfunction : sfb_tx_lanes

  sfb_pkg::sfb_width_t w_eff;
  logic sclk_rise;
  logic sclk_fall;
  logic hold_low;
  logic pause_ok;
  logic do_rx;
  logic do_tx;
  logic [7:0] tx_byte;
  logic [3:0] step;
  logic [3:0] rx_sum;
  logic [3:0] tx_sum;

  always_comb begin
    next_st = st;
    next_st.rx.valid = 1'b0;
    next_st.tx_taken = 1'b0;
    next_st.frame_start = 1'b0;
    next_st.frame_end = 1'b0;
    next_st.frame_abort = 1'b0;
    next_st.sclk_q = pin.sclk;
    // The pin is data in four-line mode, never write protect
    next_st.wp_low = ~pin.io[sfb_pkg::SFB_LANE_WP] & ~four_line_enable;
    do_rx = 1'b0;
    do_tx = 1'b0;
    tx_byte = SFB_BYTE_ZERO_W;
    rx_sum = sfb_pkg::SFB_CNT_ZERO;
    tx_sum = sfb_pkg::SFB_CNT_ZERO;

    // Edges are found from the clock level, not from its idle level
    sclk_rise = pin.sclk & ~st.sclk_q; // [R3] [R4]
    sclk_fall = ~pin.sclk & st.sclk_q; // [R3] [R4]
    hold_low = ~pin.io[sfb_pkg::SFB_LANE_HOLD];

    // Four-line transfers fall back to one line when not enabled
    w_eff = width_sel;
    next_st.quad_refused = 1'b0;
    if (width_sel == sfb_pkg::SFB_W4 && !four_line_enable) begin
      w_eff = sfb_pkg::SFB_W1; // [R7]
      next_st.quad_refused = 1'b1; // [R7]
    end
    step = sfb_step(w_eff);
    pause_ok = ~four_line_enable & (w_eff != sfb_pkg::SFB_W4); // [R13] [R18]

    case (st.state)
      sfb_pkg::SFB_ST_WAIT: begin
        // A select already low at power-up does not open a frame
        if (pin.cs_b) begin
          next_st.state = sfb_pkg::SFB_ST_DESEL; // [R10]
        end
      end
      sfb_pkg::SFB_ST_DESEL: begin
        if (!pin.cs_b) begin
          next_st.state = sfb_pkg::SFB_ST_SEL; // [R10]
          next_st.frame_start = 1'b1;
          next_st.rx_cnt = sfb_pkg::SFB_CNT_ZERO;
          next_st.tx_cnt = sfb_pkg::SFB_CNT_ZERO;
          next_st.rx_sh = SFB_BYTE_ZERO_W;
          next_st.tx_sh = SFB_BYTE_ZERO_W;
        end
      end
      sfb_pkg::SFB_ST_SEL: begin
        if (pin.cs_b) begin
          // Only the shift state ends; core operations run on
          next_st.state = sfb_pkg::SFB_ST_DESEL; // [R8] [R9]
          next_st.frame_end = 1'b1;
          next_st.frame_abort = (st.rx_cnt != sfb_pkg::SFB_CNT_ZERO); // [R20]
          next_st.rx_cnt = sfb_pkg::SFB_CNT_ZERO; // [R20]
          next_st.tx_cnt = sfb_pkg::SFB_CNT_ZERO;
        end else if (pause_ok && hold_low && !pin.sclk) begin
          // Entering on a falling edge freezes the bit that edge would send
          next_st.state = sfb_pkg::SFB_ST_PAUSE; // [R14] [R13]
        end else begin
          do_rx = sclk_rise; // [R1] [R11]
          do_tx = sclk_fall; // [R2] [R11]
        end
      end
      sfb_pkg::SFB_ST_PAUSE: begin
        if (pin.cs_b) begin
          // Deselect during a pause drops the half-done instruction
          next_st.state = sfb_pkg::SFB_ST_DESEL; // [R17]
          next_st.frame_end = 1'b1;
          next_st.frame_abort = (st.rx_cnt != sfb_pkg::SFB_CNT_ZERO);
          next_st.rx_cnt = sfb_pkg::SFB_CNT_ZERO;
          next_st.tx_cnt = sfb_pkg::SFB_CNT_ZERO;
        end else if (four_line_enable) begin
          next_st.state = sfb_pkg::SFB_ST_SEL; // [R18]
        end else if (sclk_fall && !hold_low) begin
          next_st.state = sfb_pkg::SFB_ST_SEL; // [R15]
          do_tx = 1'b1; // [R15]
        end
        // Rising edges and input data are not looked at here
      end
      default: begin
        next_st.state = sfb_pkg::SFB_ST_WAIT;
      end
    endcase

    if (do_rx) begin
      // Cut to counter width; width must not change inside a byte
      rx_sum = 4'(st.rx_cnt + step);
      next_st.rx_sh = sfb_rx_shift(st.rx_sh, pin.io, w_eff); // [R11]
      next_st.rx_cnt = rx_sum;
      if (rx_sum == sfb_pkg::SFB_BYTE_BITS) begin
        next_st.rx.valid = 1'b1;
        next_st.rx.data = sfb_rx_shift(st.rx_sh, pin.io, w_eff);
        next_st.rx_cnt = sfb_pkg::SFB_CNT_ZERO;
      end
    end

    if (do_tx) begin
      if (tx_en) begin
        // Core byte is taken at each byte boundary
        tx_byte = (st.tx_cnt == sfb_pkg::SFB_CNT_ZERO) ? tx_data : st.tx_sh;
        tx_sum = 4'(st.tx_cnt + step);
        next_st.pout.io = sfb_tx_lanes(tx_byte, w_eff); // [R2] [R11]
        next_st.pout.oe_b = ~sfb_drive(w_eff); // [R5] [R6]
        next_st.tx_sh = tx_byte << step;
        next_st.tx_cnt = tx_sum;
        next_st.tx_taken = (st.tx_cnt == sfb_pkg::SFB_CNT_ZERO);
        if (tx_sum == sfb_pkg::SFB_BYTE_BITS) begin
          next_st.tx_cnt = sfb_pkg::SFB_CNT_ZERO;
        end
      end else begin
        next_st.pout.oe_b = sfb_pkg::SFB_OE_NONE; // [R2]
        next_st.pout.io = sfb_pkg::SFB_IO_IDLE;
      end
    end

    // Counters and shift registers are left alone outside selection paths
    if (next_st.state != sfb_pkg::SFB_ST_SEL) begin
      next_st.pout.oe_b = sfb_pkg::SFB_OE_NONE; // [R8] [R16] [R21]
      next_st.pout.io = sfb_pkg::SFB_IO_IDLE;
    end

    // Registered so the status outputs come straight from flops
    next_st.selected = (next_st.state == sfb_pkg::SFB_ST_SEL) ||
                       (next_st.state == sfb_pkg::SFB_ST_PAUSE);
    next_st.paused = (next_st.state == sfb_pkg::SFB_ST_PAUSE);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= FE_RESET;
    end else begin
      st <= next_st;
    end
  end

  sfb_block_lock u_lock (
    .clk(clk),
    .rst_b(rst_b),
    .set_stb(set_stb),
    .set_data(set_data),
    .wp_low(st.wp_low), // [R12]
    .lock_reg(lock_reg),
    .set_reject(set_reject)
  );

  assign pins_out = st.pout;
  assign tx_taken = st.tx_taken;
  assign rx = st.rx;
  assign selected = st.selected;
  assign paused = st.paused;
  assign frame_start = st.frame_start;
  assign frame_end = st.frame_end;
  assign frame_abort = st.frame_abort;
  assign quad_refused = st.quad_refused;

endmodule : sfb_front_end

// ===== sfb_pkg.sv
package sfb_pkg;

  // Pin lanes of the serial bus
  localparam int unsigned SFB_LANES = 4;
  localparam int unsigned SFB_LANE_SI = 0;
  localparam int unsigned SFB_LANE_SO = 1;
  localparam int unsigned SFB_LANE_WP = 2;
  localparam int unsigned SFB_LANE_HOLD = 3;

  // Bits per byte and bits moved per clock edge
  localparam logic [3:0] SFB_BYTE_BITS = 4'h8;
  localparam logic [3:0] SFB_STEP_W1 = 4'h1;
  localparam logic [3:0] SFB_STEP_W2 = 4'h2;
  localparam logic [3:0] SFB_STEP_W4 = 4'h4;
  localparam logic [3:0] SFB_CNT_ZERO = 4'h0;

  // Lanes driven per width; output enables are active low
  localparam logic [3:0] SFB_DRIVE_W1 = 4'h2;
  localparam logic [3:0] SFB_DRIVE_W2 = 4'h3;
  localparam logic [3:0] SFB_DRIVE_W4 = 4'hf;
  localparam logic [3:0] SFB_OE_NONE = 4'hf;
  localparam logic [3:0] SFB_IO_IDLE = 4'h0;

  localparam logic [7:0] SFB_BYTE_ZERO = 8'h00;

  typedef enum logic [1:0] {
    SFB_W1,
    SFB_W2,
    SFB_W4
  } sfb_width_t;

  typedef enum logic [1:0] {
    SFB_ST_WAIT,
    SFB_ST_DESEL,
    SFB_ST_SEL,
    SFB_ST_PAUSE
  } sfb_state_t;

  typedef struct packed {
    logic sclk;
    logic cs_b;
    logic [3:0] io;
  } sfb_pin_in_t;

  typedef struct packed {
    logic [3:0] io;
    logic [3:0] oe_b;
  } sfb_pin_out_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } sfb_byte_t;

  // Block lock register, bit 7 down to bit 0
  typedef struct packed {
    logic protect_reg_write_lock;
    logic rsv_6;
    logic protect_range_sel_2;
    logic protect_range_sel_1;
    logic protect_range_sel_0;
    logic range_flip;
    logic range_complement;
    logic rsv_0;
  } sfb_lock_reg_t;

  localparam sfb_lock_reg_t SFB_LOCK_RESET = 8'h00;

endpackage : sfb_pkg

// ===== sfb_pin_sync.sv
`timescale 1ns/1ps
module sfb_pin_sync #(
  parameter int unsigned WIDTH = 6
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] stable
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
  } sfb_sync_t;

  sfb_sync_t st;
  sfb_sync_t next_st;

  // Stage one only feeds stage two; the filter looks at stages two and three
  always_comb begin
    next_st = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.stable = (st.s2 & st.s3) | (st.stable & (st.s2 ^ st.s3));
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign stable = st.stable;

endmodule : sfb_pin_sync

// ===== sfb_block_lock.sv
`timescale 1ns/1ps
module sfb_block_lock (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic set_stb,
  input wire sfb_pkg::sfb_lock_reg_t set_data,
  input wire logic wp_low,
  output sfb_pkg::sfb_lock_reg_t lock_reg,
  output logic set_reject
);

  typedef struct packed {
    sfb_pkg::sfb_lock_reg_t regv;
    logic reject;
  } sfb_lock_state_t;

  sfb_lock_state_t st;
  sfb_lock_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.reject = 1'b0;
    if (set_stb) begin
      if (st.regv.protect_reg_write_lock && wp_low) begin
        // Range bits stay frozen so the protected region stays protected
        next_st.reject = 1'b1; // [R12]
      end else begin
        next_st.regv = set_data;
        next_st.regv.rsv_6 = 1'b0;
        next_st.regv.rsv_0 = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '{regv: sfb_pkg::SFB_LOCK_RESET, reject: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign lock_reg = st.regv;
  assign set_reject = st.reject;

endmodule : sfb_block_lock

// ===== sfb_front_end_asserts.sv
`timescale 1ns/1ps
module sfb_front_end_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire sfb_pkg::sfb_pin_in_t pins_in,
  input wire sfb_pkg::sfb_pin_out_t pins_out,
  input wire logic four_line_enable,
  input wire sfb_pkg::sfb_width_t width_sel,
  input wire sfb_pkg::sfb_byte_t rx,
  input wire logic selected,
  input wire logic paused,
  input wire logic frame_start,
  input wire logic frame_end,
  input wire logic frame_abort,
  input wire logic quad_refused,
  input wire logic set_stb,
  input wire sfb_pkg::sfb_lock_reg_t set_data,
  input wire sfb_pkg::sfb_lock_reg_t lock_reg,
  input wire logic set_reject
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic prev_cs;
  logic seen;
  logic prev_sclk;
  logic [3:0] since_fall;
  // Two high samples are the least the pin filter can accept
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_cs <= 1'b0;
      seen <= 1'b0;
      prev_sclk <= 1'b0;
      since_fall <= 4'hf;
    end else begin
      prev_cs <= pins_in.cs_b;
      prev_sclk <= pins_in.sclk;
      if (pins_in.cs_b && prev_cs) seen <= 1'b1;
      if (prev_sclk && !pins_in.sclk) since_fall <= 4'h0;
      else if (since_fall != 4'hf) since_fall <= since_fall + 4'h1;
    end
  end
  sequence s_desel; pins_in.cs_b [*7]; endsequence
  sequence s_wp_low; !pins_in.io[2] [*6]; endsequence
  a_desel_hiz: assert property (s_desel |-> pins_out.oe_b == 4'hf)
    else $error("lanes driven while deselected");
  a_pause_hiz: assert property (paused [*2] |-> pins_out.oe_b == 4'hf)
    else $error("lanes driven while paused");
  a_pause_no_rx: assert property (paused [*2] |-> !rx.valid)
    else $error("byte taken while paused");
  a_pause_in_frame: assert property (paused |-> selected)
    else $error("pause outside a frame");
  a_quad_no_pause: assert property (four_line_enable [*4] |-> !paused)
    else $error("pause with four-line enable");
  a_quad_refused: assert property (
    (width_sel == sfb_pkg::SFB_W4 && !four_line_enable) [*2] |-> quad_refused)
    else $error("four-line not refused");
  a_lock_reject: assert property (s_wp_low ##0 (set_stb &&
    lock_reg.protect_reg_write_lock && !four_line_enable)
    |=> set_reject && $stable(lock_reg))
    else $error("locked write not refused");
  a_lock_write: assert property (set_stb &&
    !lock_reg.protect_reg_write_lock
    |=> !set_reject && lock_reg == ($past(set_data) & 8'hbe))
    else $error("unlocked write lost");
  a_unarmed_idle: assert property (!seen |-> !selected && !frame_start)
    else $error("frame before first deselect");
  a_abort_end: assert property (frame_abort |-> frame_end)
    else $error("abort without frame end");
  a_drive_after_fall: assert property ($changed(pins_out.io[1]) &&
    !pins_out.oe_b[1] && !$past(pins_out.oe_b[1]) |-> since_fall <= 4'h7)
    else $error("output moved away from a falling edge");
endmodule : sfb_front_end_asserts

bind sfb_front_end sfb_front_end_asserts i_chk (
  .clk, .rst_b, .pins_in, .pins_out, .four_line_enable, .width_sel, .rx,
  .selected, .paused, .frame_start, .frame_end, .frame_abort,
  .quad_refused, .set_stb, .set_data, .lock_reg, .set_reject
);

// ===== sfb_host_model.sv
`timescale 1ns/1ps
module sfb_host_model (
  input wire logic clk,
  input wire sfb_pkg::sfb_pin_out_t pins_out,
  output sfb_pkg::sfb_pin_in_t pins_in
);
  logic sclk = 1'b0;
  logic cs_b = 1'b0; // Low from power-up, so no select fall yet
  logic [3:0] hio = 4'hc;
  logic [3:0] hoe = 4'hc;
  logic [3:0] junk = 4'h5;
  // Released lanes toggle so a stale value never passes
  always @(negedge clk) junk <= ~junk;
  always_comb begin
    pins_in.sclk = sclk;
    pins_in.cs_b = cs_b;
    for (int i = 0; i < 4; i++) begin
      pins_in.io[i] = !pins_out.oe_b[i] ? pins_out.io[i] :
        (hoe[i] ? hio[i] : junk[i]);
    end
  end
  task half;
    repeat (8) @(negedge clk);
  endtask : half
  task sel(input logic m3);
    sclk = m3;
    half;
    cs_b = 1'b0;
    half;
  endtask : sel
  task desel(input logic m3);
    sclk = m3;
    half;
    cs_b = 1'b1;
    hio[3:2] = 2'b11;
    hoe = 4'hc;
    half;
    half;
  endtask : desel
  // Select stays low across the pause
  task xfer(input int n, input logic [7:0] d, input bit drv, input int pk,
    output logic [7:0] q);
    int o;
    o = (n == 1) ? 1 : 0;
    // Single line keeps serial_in driven while reading
    hoe = (n == 4) ? {4{drv}} :
      {2'b11, drv && n == 2, drv || n == 1};
    for (int s = 0; s < 8 / n; s++) begin
      if (s == pk) begin
        hio[3] = 1'b0;
        half;
        sclk = 1'b0;
        half;
        sclk = 1'b1;
        hio[0] = ~hio[0];
        half;
        // Release with the clock high; the next fall resumes
        hio[3] = 1'b1;
        half;
      end
      sclk = 1'b0;
      for (int l = 0; l < n; l++) hio[l] = d[8 - n * (s + 1) + l];
      half;
      sclk = 1'b1;
      half;
      for (int l = 0; l < n; l++) q[8 - n * (s + 1) + l] = pins_in.io[l + o];
    end
  endtask : xfer
endmodule : sfb_host_model

// ===== tb_sfb_front_end.sv
`timescale 1ns/1ps
module tb_sfb_front_end;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  sfb_pkg::sfb_pin_in_t pins_in;
  sfb_pkg::sfb_pin_out_t pins_out;
  logic four_line_enable = 1'b0;
  sfb_pkg::sfb_width_t width_sel = sfb_pkg::SFB_W1;
  logic tx_en = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_taken, selected, paused, frame_start, frame_end, frame_abort;
  logic quad_refused, set_reject;
  sfb_pkg::sfb_byte_t rx;
  logic set_stb = 1'b0;
  sfb_pkg::sfb_lock_reg_t set_data = 8'h00;
  sfb_pkg::sfb_lock_reg_t lock_reg;
  logic [7:0] exp_q[$];
  logic [7:0] q, d, lk, v;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int pcnt = 0;
  int acnt = 0;
  int tcnt = 0;
  int n, pk;
  always #2 clk = ~clk;
  sfb_front_end i_dut (.clk, .rst_b, .pins_in, .pins_out, .four_line_enable,
    .width_sel, .tx_en, .tx_data, .tx_taken, .rx, .selected, .paused,
    .frame_start, .frame_end, .frame_abort, .quad_refused, .set_stb,
    .set_data, .lock_reg, .set_reject);
  sfb_host_model i_host (.clk, .pins_out, .pins_in);
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task finish_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task set_lock(input logic [7:0] val, input logic rej, input logic [7:0] e);
    @(negedge clk);
    set_stb = 1'b1;
    set_data = val;
    @(negedge clk);
    set_stb = 1'b0;
    check(set_reject, rej);
    check(lock_reg, e);
  endtask : set_lock
  // A byte with no note pending is itself a mismatch
  always @(negedge clk) begin
    if (rx.valid === 1'b1) begin
      if (exp_q.size() == 0) check(8'h01, 8'h00);
      else check(rx.data, exp_q.pop_front());
    end
    if (paused === 1'b1) pcnt++;
    if (frame_abort === 1'b1) acnt++;
    if (tx_taken === 1'b1) tcnt++;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      finish_test;
    end
  end
  initial begin
    void'($urandom(32'he3c5_d899));
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    check(pins_out.oe_b, 4'hf);
    check(lock_reg, 8'h00);
    i_host.xfer(1, 8'($urandom), 1, 99, q);
    i_host.desel(1'b0);
    i_host.sel(1'b0);
    i_host.xfer(2, 8'($urandom), 1, 99, q);
    i_host.desel(1'b0);
    for (int c = 0; c < 4; c++) begin
      four_line_enable = (c == 2);
      width_sel = (c < 2) ? sfb_pkg::sfb_width_t'(c) : sfb_pkg::SFB_W4;
      n = (c == 1) ? 2 : (c == 2) ? 4 : 1;
      pk = (c == 2) ? 99 : 2;
      i_host.sel(c[0]);
      // Pause lane held low in four-line data
      d = 8'($urandom) & ((c == 2) ? 8'h77 : 8'hff);
      exp_q.push_back(d);
      i_host.xfer(n, d, 1, pk, q);
      tx_data = 8'($urandom);
      // Rising edges keep sampling; wide lanes carry our own output back
      exp_q.push_back((n == 1) ? d : tx_data);
      tx_en = 1'b1;
      i_host.xfer(n, d, 0, pk, q);
      tx_en = 1'b0;
      check(q, tx_data);
      check(quad_refused, c == 3);
      i_host.desel(c[0]);
    end
    lk = 8'($urandom) | 8'h80;
    set_lock(lk, 1'b0, lk & 8'hbe);
    i_host.hio[2] = 1'b0;
    repeat (8) @(negedge clk);
    set_lock(8'($urandom), 1'b1, lk & 8'hbe);
    four_line_enable = 1'b1;
    v = 8'($urandom) & 8'h7f;
    set_lock(v, 1'b0, v & 8'hbe);
    four_line_enable = 1'b0;
    v = 8'($urandom);
    set_lock(v, 1'b0, v & 8'hbe);
    check(8'(pcnt != 0), 8'h01);
    check(8'(acnt), 8'h01);
    check(8'(exp_q.size()), 8'h00);
    check(8'(tcnt), 8'h04);
    finish_test;
  end
endmodule : tb_sfb_front_end
